// ---- pkg/fcap_pkg.sv ----
// Shared constants and types for the free-running capture timer
package fcap_pkg;

	// Register byte addresses, one 32-bit word each, data in bits 7:0
	localparam logic [7:0] OFF_CR1 = 8'h00;
	localparam logic [7:0] OFF_CR2 = 8'h04;
	localparam logic [7:0] OFF_SR = 8'h08;
	localparam logic [7:0] OFF_CHR = 8'h0C;
	localparam logic [7:0] OFF_CLR = 8'h10;
	localparam logic [7:0] OFF_ALT_COUNT_HIGH_BYTE = 8'h14;
	localparam logic [7:0] OFF_ALT_COUNT_LOW_BYTE = 8'h18;
	localparam logic [7:0] OFF_IC1H = 8'h1C;
	localparam logic [7:0] OFF_IC1L = 8'h20;
	localparam logic [7:0] OFF_IC2H = 8'h24;
	localparam logic [7:0] OFF_IC2L = 8'h28;
	localparam logic [7:0] OFF_CTL = 8'h2C;

	// First control register bits
	localparam int CR1_CAPTURE_IRQ_ENABLE = 7;
	localparam int CR1_OVERFLOW_IRQ_ENABLE = 5;
	localparam int CR1_IEDG1 = 1;
	// Second control register bits
	localparam int CR2_PWM = 5;
	localparam int CR2_OPM = 4;
	localparam int CR2_CC_HI = 3;
	localparam int CR2_CC_LO = 2;
	localparam int CR2_IEDG2 = 1;
	localparam int CR2_EXT_CLOCK_EDGE_SELECT = 0;
	// Status register bits
	localparam int SR_ICF1 = 7;
	localparam int SR_TOF = 5;
	localparam int SR_ICF2 = 4;
	// Core control register bits
	localparam int CTL_MASK = 0;
	localparam int CTL_HALT = 1;

	// Reset, reload and wrap values
	localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [7:0] CR_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h01;

	// Clock select encodings and prescaler masks
	localparam logic [1:0] CC_DIV4 = 2'h0;
	localparam logic [1:0] CC_DIV2 = 2'h1;
	localparam logic [1:0] CC_DIV8 = 2'h2;
	localparam logic [1:0] CC_EXT = 2'h3;
	localparam logic [2:0] PRE_M2 = 3'h1;
	localparam logic [2:0] PRE_M4 = 3'h3;
	localparam logic [2:0] PRE_M8 = 3'h7;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} fcap_wb_req_t;

	// Pin synchroniser state
	typedef struct packed {
		logic [2:0] s;
		logic lvl;
		logic rise;
		logic fall;
	} fcap_sync_t;

	// Whole timer state
	typedef struct packed {
		logic [15:0] cnt;
		logic [2:0] pre;
		logic [7:0] lo_buf;
		logic buf_valid;
		logic overflow_flag;
		logic tof_arm;
		logic [1:0] icf;
		logic [1:0] icf_arm;
		logic [1:0] inhibit;
		logic [1:0][15:0] icr;
		logic [7:0] cr1;
		logic [7:0] cr2;
		logic [7:0] ctl;
		logic ack;
		logic [31:0] rdat;
		logic irq;
	} fcap_state_t;

endpackage : fcap_pkg

// ---- src/fcap_sync.sv ----
// Three-stage pin synchroniser with agreed-level edge pulses
`timescale 1ns/1ps
`default_nettype none

module fcap_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw pin
	input wire logic pin_i,
	// Edge pulses, one cycle each
	output logic rise_o,
	output logic fall_o
);

	fcap_pkg::fcap_sync_t st_q;
	fcap_pkg::fcap_sync_t st_d;

	// Shift chain; level moves only once stages two and three agree
	always_comb begin
		st_d = st_q;
		st_d.s = {st_q.s[1:0], pin_i};
		if (st_q.s[2] == st_q.s[1]) begin
			st_d.lvl = st_q.s[2];
		end
		st_d.rise = st_d.lvl & ~st_q.lvl;
		st_d.fall = ~st_d.lvl & st_q.lvl;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rise_o = st_q.rise;
	assign fall_o = st_q.fall;

endmodule : fcap_sync

`default_nettype wire

// ---- src/fcap_timer.sv ----
// Free-running 16-bit timer with two input captures on a Wishbone slave
//
// How it works
// R1 - 16-bit counter on prescaled or external clock
// R2 - Low byte write reloads counter to FFFC
// R3 - Reset value FFFC, the only reload value
// R4 - Both views equal; alternate low never clears overflow
// R5 - High byte read freezes low byte buffer
// R6 - After pair, low read returns live byte
// R7 - Wrap FFFF to 0000 sets overflow flag
// R8 - Overflow request needs enable and clear mask
// R9 - Overflow cleared by status read, then low access
// R10 - Wait ignored; halt freezes the counter
// R11 - Clock select 11 picks external pin
// R12 - Edge bit picks external clock transition
// R13 - External events synchronised before counting
// R14 - External clock slower than quarter CPU clock
// R15 - Capture copies counter on active pin edge
// R16 - Per-channel edge select bit for captures
// R17 - Capture sets flag; shared enable raises request
// R18 - Capture flag cleared by status read, low read
// R19 - High byte read blocks captures until low
// R20 - Capture register holds most recent event
// R21 - Pulse modes leave only channel two capturing
// R22 - Capture pins always feed capture logic
// R23 - Bus gives single-strobe byte accesses
`timescale 1ns/1ps
`default_nettype none

module fcap_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Wishbone slave
	input wire fcap_pkg::fcap_wb_req_t wb_req,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// Timer pins
	input wire logic external_count_pin,
	input wire logic [1:0] capture_input_pin,
	// Timer interrupt request
	output logic timer_irq
);

	logic [1:0] rst_sync_q;
	logic rst_n;
	fcap_pkg::fcap_state_t st_q;
	fcap_pkg::fcap_state_t st_d;
	logic [2:0] pin_raw;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;
	logic acc;
	logic rd;
	logic wr;
	logic acc_clr;
	logic acc_alt_count_low_byte;
	logic rd_hi;
	logic rd_lo;
	logic reload;
	logic tick;
	logic run_tick;
	logic pulse_mode;
	logic [1:0] cap_ev;
	logic [1:0] cap_ok;
	logic pend;

	// Reset release through two flip-flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Pins: bit 0 external clock, bits 2:1 capture inputs
	assign pin_raw = {capture_input_pin, external_count_pin};
	for (genvar gi = 0; gi < 3; gi++) begin : g_sync
		fcap_sync u_sync (
			.clk(ref_clk),
			.rst_n(rst_n),
			.pin_i(pin_raw[gi]),
			.rise_o(pin_rise[gi]),
			.fall_o(pin_fall[gi])
		);
	end

	// Bus decode; one access per strobe since ack blocks a repeat
	// Side effects land at the take edge; ack is registered at that same edge
	// Writes need byte lane 0, reads ignore the lane selects
	assign acc = wb_req.cyc & wb_req.stb & ~st_q.ack; // R23
	assign rd = acc & ~wb_req.we;
	assign wr = acc & wb_req.we & wb_req.sel[0];
	assign acc_clr = acc & (wb_req.adr == fcap_pkg::OFF_CLR);
	assign acc_alt_count_low_byte = acc & (wb_req.adr == fcap_pkg::OFF_ALT_COUNT_LOW_BYTE);
	assign rd_hi = rd & ((wb_req.adr == fcap_pkg::OFF_CHR) | (wb_req.adr == fcap_pkg::OFF_ALT_COUNT_HIGH_BYTE));
	assign rd_lo = rd & (acc_clr | acc_alt_count_low_byte);
	assign reload = wr & (acc_clr | acc_alt_count_low_byte); // R2

	// Timer clock: prescaler taps or synchronised external edge
	always_comb begin
		case (st_q.cr2[fcap_pkg::CR2_CC_HI:fcap_pkg::CR2_CC_LO])
			fcap_pkg::CC_DIV2: tick = (st_q.pre & fcap_pkg::PRE_M2) == fcap_pkg::PRE_M2; // R1
			fcap_pkg::CC_DIV4: tick = (st_q.pre & fcap_pkg::PRE_M4) == fcap_pkg::PRE_M4;
			fcap_pkg::CC_DIV8: tick = (st_q.pre & fcap_pkg::PRE_M8) == fcap_pkg::PRE_M8;
			fcap_pkg::CC_EXT: begin
				tick = st_q.cr2[fcap_pkg::CR2_EXT_CLOCK_EDGE_SELECT] ? pin_rise[0] : pin_fall[0]; // R11 R12 R13
			end
			default: tick = 1'h0;
		endcase
	end
	assign run_tick = tick & ~st_q.ctl[fcap_pkg::CTL_HALT]; // R10

	// Capture events with per-channel edge selection
	assign cap_ev[0] = st_q.cr1[fcap_pkg::CR1_IEDG1] ? pin_rise[1] : pin_fall[1]; // R16 R22
	assign cap_ev[1] = st_q.cr2[fcap_pkg::CR2_IEDG2] ? pin_rise[2] : pin_fall[2]; // R16 R22
	assign pulse_mode = st_q.cr2[fcap_pkg::CR2_OPM] | st_q.cr2[fcap_pkg::CR2_PWM];
	assign cap_ok[0] = cap_ev[0] & ~st_q.inhibit[0] & ~pulse_mode; // R21 R19
	assign cap_ok[1] = cap_ev[1] & ~st_q.inhibit[1]; // R19

	// Pending timer request before the global mask
	assign pend = (st_q.overflow_flag & st_q.cr1[fcap_pkg::CR1_OVERFLOW_IRQ_ENABLE])
		| ((|st_q.icf) & st_q.cr1[fcap_pkg::CR1_CAPTURE_IRQ_ENABLE]);

	// Next-state logic for the whole timer
	always_comb begin
		logic [7:0] rbyte;
		rbyte = 8'h00;
		st_d = st_q;
		st_d.ack = acc; // R23
		st_d.pre = st_q.ctl[fcap_pkg::CTL_HALT] ? st_q.pre : st_q.pre + 3'h1;

		// Counter: reload beats counting
		if (reload) begin
			st_d.cnt = fcap_pkg::CNT_RELOAD; // R2 R3
		end else if (run_tick) begin
			st_d.cnt = st_q.cnt + 16'h0001; // R1
		end

		// Overflow flag: clear on armed low access, set wins
		if (acc_clr & st_q.tof_arm) begin
			st_d.overflow_flag = 1'h0; // R9
			st_d.tof_arm = 1'h0;
		end
		if (rd & (wb_req.adr == fcap_pkg::OFF_SR)) begin
			st_d.tof_arm = st_q.overflow_flag; // R9
			st_d.icf_arm = st_q.icf; // R18
		end
		if (run_tick & ~reload & (st_q.cnt == fcap_pkg::CNT_MAX)) begin
			st_d.overflow_flag = 1'h1; // R7
		end

		// Capture flag clear by low-byte access after status read
		if (acc & (wb_req.adr == fcap_pkg::OFF_IC1L) & st_q.icf_arm[0]) begin
			st_d.icf[0] = 1'h0; // R18
			st_d.icf_arm[0] = 1'h0;
		end
		if (acc & (wb_req.adr == fcap_pkg::OFF_IC2L) & st_q.icf_arm[1]) begin
			st_d.icf[1] = 1'h0; // R18
			st_d.icf_arm[1] = 1'h0;
		end

		// Capture inhibit from high read until low read
		if (rd & (wb_req.adr == fcap_pkg::OFF_IC1H)) begin
			st_d.inhibit[0] = 1'h1; // R19
		end
		if (rd & (wb_req.adr == fcap_pkg::OFF_IC1L)) begin
			st_d.inhibit[0] = 1'h0;
		end
		if (rd & (wb_req.adr == fcap_pkg::OFF_IC2H)) begin
			st_d.inhibit[1] = 1'h1; // R19
		end
		if (rd & (wb_req.adr == fcap_pkg::OFF_IC2L)) begin
			st_d.inhibit[1] = 1'h0;
		end

		// Captures take the live count; newest overwrites
		for (int i = 0; i < 2; i++) begin
			if (cap_ok[i]) begin
				st_d.icr[i] = st_q.cnt; // R15 R20
				st_d.icf[i] = 1'h1; // R17
			end
		end

		// Low byte buffer for the 16-bit read pair
		if (rd_hi & ~st_q.buf_valid) begin
			st_d.lo_buf = st_q.cnt[7:0]; // R5
			st_d.buf_valid = 1'h1;
		end
		if (rd_lo | reload) begin
			st_d.buf_valid = 1'h0; // R6
		end

		// Software-written control
		if (wr & (wb_req.adr == fcap_pkg::OFF_CR1)) begin
			st_d.cr1 = wb_req.dat[7:0];
		end
		if (wr & (wb_req.adr == fcap_pkg::OFF_CR2)) begin
			st_d.cr2 = wb_req.dat[7:0];
		end
		if (wr & (wb_req.adr == fcap_pkg::OFF_CTL)) begin
			st_d.ctl = wb_req.dat[7:0];
		end
		// A pending request wakes the timer from halt
		if (pend) begin
			st_d.ctl[fcap_pkg::CTL_HALT] = 1'h0; // R10
		end

		// Read data; unmapped addresses read zero
		case (wb_req.adr)
			fcap_pkg::OFF_CR1: rbyte = st_q.cr1;
			fcap_pkg::OFF_CR2: rbyte = st_q.cr2;
			fcap_pkg::OFF_SR: begin
				rbyte[fcap_pkg::SR_ICF1] = st_q.icf[0];
				rbyte[fcap_pkg::SR_TOF] = st_q.overflow_flag;
				rbyte[fcap_pkg::SR_ICF2] = st_q.icf[1];
			end
			fcap_pkg::OFF_CHR, fcap_pkg::OFF_ALT_COUNT_HIGH_BYTE: rbyte = st_q.cnt[15:8]; // R4
			fcap_pkg::OFF_CLR, fcap_pkg::OFF_ALT_COUNT_LOW_BYTE: begin
				rbyte = st_q.buf_valid ? st_q.lo_buf : st_q.cnt[7:0]; // R4 R5 R6
			end
			fcap_pkg::OFF_IC1H: rbyte = st_q.icr[0][15:8];
			fcap_pkg::OFF_IC1L: rbyte = st_q.icr[0][7:0];
			fcap_pkg::OFF_IC2H: rbyte = st_q.icr[1][15:8];
			fcap_pkg::OFF_IC2L: rbyte = st_q.icr[1][7:0];
			fcap_pkg::OFF_CTL: rbyte = st_q.ctl;
			default: rbyte = 8'h00;
		endcase
		st_d.rdat = rd ? {24'h00_0000, rbyte} : 32'h0000_0000;

		// Request only while the global mask is clear
		st_d.irq = pend & ~st_q.ctl[fcap_pkg::CTL_MASK]; // R8 R17
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.cnt <= fcap_pkg::CNT_RELOAD; // R3
			st_q.cr1 <= fcap_pkg::CR_RST;
			st_q.cr2 <= fcap_pkg::CR_RST;
			st_q.ctl <= fcap_pkg::CTL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops
	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.rdat;
	assign timer_irq = st_q.irq;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_reload;
		reload |=> st_q.cnt == fcap_pkg::CNT_RELOAD;
	endproperty
	a_reload: assert property (p_reload) else $error("write to low byte did not reload"); // R2

	property p_rst_val;
		$rose(rst_n) |-> st_q.cnt == fcap_pkg::CNT_RELOAD;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("counter not at reload after reset"); // R3

	property p_alt_keeps_tof;
		acc_alt_count_low_byte & st_q.overflow_flag |=> st_q.overflow_flag;
	endproperty
	a_alt_keeps_tof: assert property (p_alt_keeps_tof) else $error("overflow flag lost"); // R4

	property p_buf_frozen;
		rd_hi & st_q.buf_valid |=> st_q.lo_buf == $past(st_q.lo_buf) && st_q.buf_valid;
	endproperty
	a_buf_frozen: assert property (p_buf_frozen) else $error("low byte buffer changed"); // R5

	property p_live_low;
		rd_lo & ~st_q.buf_valid |=> wb_dat_o[7:0] == $past(st_q.cnt[7:0]) && wb_ack_o;
	endproperty
	a_live_low: assert property (p_live_low) else $error("lone low read not live"); // R6

	property p_wrap;
		run_tick & ~reload & (st_q.cnt == fcap_pkg::CNT_MAX)
			|=> st_q.overflow_flag && st_q.cnt == fcap_pkg::CNT_ZERO;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap did not set overflow"); // R7

	property p_irq_ovf;
		st_q.overflow_flag & st_q.cr1[fcap_pkg::CR1_OVERFLOW_IRQ_ENABLE] & ~st_q.ctl[fcap_pkg::CTL_MASK] |=> timer_irq;
	endproperty
	a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request missing"); // R8

	property p_irq_masked;
		st_q.ctl[fcap_pkg::CTL_MASK] |=> !timer_irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("request while masked"); // R8

	property p_tof_hold;
		st_q.overflow_flag & ~st_q.tof_arm |=> st_q.overflow_flag;
	endproperty
	a_tof_hold: assert property (p_tof_hold) else $error("overflow cleared unarmed"); // R9

	property p_halt;
		st_q.ctl[fcap_pkg::CTL_HALT] & ~reload |=> st_q.cnt == $past(st_q.cnt);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved in halt"); // R10

	property p_capture;
		cap_ok[1] |=> st_q.icr[1] == $past(st_q.cnt) && st_q.icf[1];
	endproperty
	a_capture: assert property (p_capture) else $error("capture two missed"); // R15

	property p_inhibit;
		st_q.inhibit[0] |=> st_q.icr[0] == $past(st_q.icr[0]);
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("capture while inhibited"); // R19

	property p_pulse_mode;
		pulse_mode & ~st_q.icf[0] |=> !st_q.icf[0];
	endproperty
	a_pulse_mode: assert property (p_pulse_mode) else $error("channel one captured"); // R21

	property p_ack;
		acc |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer timing wrong"); // R23

	property p_irq_cap;
		(|st_q.icf) & st_q.cr1[fcap_pkg::CR1_CAPTURE_IRQ_ENABLE] & ~st_q.ctl[fcap_pkg::CTL_MASK] |=> timer_irq;
	endproperty
	a_irq_cap: assert property (p_irq_cap) else $error("capture request missing"); // R17

	property p_ext_edge;
		(st_q.cr2[fcap_pkg::CR2_CC_HI:fcap_pkg::CR2_CC_LO] == fcap_pkg::CC_EXT)
			& st_q.cr2[fcap_pkg::CR2_EXT_CLOCK_EDGE_SELECT] & pin_rise[0] & ~st_q.ctl[fcap_pkg::CTL_HALT] & ~reload
			|=> st_q.cnt == $past(st_q.cnt) + 16'h0001;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("external edge not counted"); // R12

	c_overflow: cover property (run_tick & (st_q.cnt == fcap_pkg::CNT_MAX));
	c_capture: cover property (cap_ok[0] ##[1:20] cap_ok[1]);
	c_read_pair: cover property (rd_hi ##[2:10] rd_lo);
	c_tof_clear: cover property (st_q.overflow_flag ##1 !st_q.overflow_flag);
	c_lone_low: cover property (rd_lo & ~st_q.buf_valid);

endmodule : fcap_timer

`default_nettype wire

// ---- dv/fcap_pin_src.sv ----
// Model of the outside sources driving the timer pins
`timescale 1ns/1ps
`default_nettype none

module fcap_pin_src (
	// Clock
	input wire logic ref_clk,
	// Timer pins
	output logic external_count_pin,
	output logic [1:0] capture_input_pin
);
	// Pins idle low
	initial begin
		external_count_pin = 1'b0;
		capture_input_pin = 2'h0;
	end

	// Whole clock pulses, each level held four cycles
	task burst(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			external_count_pin <= 1'b1;
			repeat (4) @(posedge ref_clk);
			external_count_pin <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
		repeat (8) @(posedge ref_clk);
	endtask : burst

	// One capture pin level change, then time to settle
	task set_cap(input int ch, input logic v);
		@(posedge ref_clk);
		capture_input_pin[ch] <= v;
		repeat (8) @(posedge ref_clk);
	endtask : set_cap
endmodule : fcap_pin_src
`default_nettype wire

// ---- dv/testbench.sv ----
// Register-level test of the capture timer
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic ref_clk;
	logic resetn;
	fcap_pkg::fcap_wb_req_t req;
	logic wb_ack_o;
	logic [31:0] wb_dat_o;
	logic external_count_pin;
	logic [1:0] capture_input_pin;
	logic timer_irq;
	int fail_count;
	int checks_done;
	int cycles;
	logic [7:0] v1;
	logic [7:0] v2;

	// Device and pin sources
	fcap_timer u_fcap_timer (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.wb_req(req),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.external_count_pin(external_count_pin),
		.capture_input_pin(capture_input_pin),
		.timer_irq(timer_irq)
	);
	fcap_pin_src u_fcap_pin_src (
		.ref_clk(ref_clk),
		.external_count_pin(external_count_pin),
		.capture_input_pin(capture_input_pin)
	);

	// 50 ns clock
	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;

	// Verdict and end of run
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			end_of_test();
		end
	end

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle, held until ack
	task wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge ref_clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h00_0000, d}};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
	endtask : wb

	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d, v2);
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		chk({24'h00_0000, q}, {24'h00_0000, e});
	endtask : rdchk

	initial begin
		req = '0;
		resetn = 1'b0;
		fail_count = 0;
		checks_done = 0;
		cycles = 0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		// Reset values, unmapped place
		rdchk(fcap_pkg::OFF_CR1, 8'h00);
		rdchk(fcap_pkg::OFF_CR2, 8'h00);
		rdchk(fcap_pkg::OFF_CTL, 8'h01);
		rdchk(8'h30, 8'h00);
		// Halt, reload, both views
		wr(fcap_pkg::OFF_CTL, 8'h03);
		wr(fcap_pkg::OFF_CLR, 8'h55);
		rdchk(fcap_pkg::OFF_CHR, 8'hFF);
		rdchk(fcap_pkg::OFF_CLR, 8'hFC);
		rdchk(fcap_pkg::OFF_ALT_COUNT_HIGH_BYTE, 8'hFF);
		rdchk(fcap_pkg::OFF_ALT_COUNT_LOW_BYTE, 8'hFC);
		// Buffered low byte survives counting and a second high read
		rdchk(fcap_pkg::OFF_CHR, 8'hFF);
		wr(fcap_pkg::OFF_CTL, 8'h01);
		repeat (40) @(posedge ref_clk);
		wr(fcap_pkg::OFF_CTL, 8'h03);
		wb(1'b0, fcap_pkg::OFF_CHR, 8'h00, v1);
		rdchk(fcap_pkg::OFF_CLR, 8'hFC);
		wb(1'b0, fcap_pkg::OFF_CLR, 8'h00, v1);
		wb(1'b0, fcap_pkg::OFF_ALT_COUNT_LOW_BYTE, 8'h00, v2);
		chk({24'h00_0000, v1}, {24'h00_0000, v2});
		chk({31'h0000_0000, v1 != 8'hFC}, 32'h0000_0001);
		// Overflow flag, enable, mask and two-step clear
		rdchk(fcap_pkg::OFF_SR, 8'h20);
		wr(fcap_pkg::OFF_CLR, 8'h00);
		rdchk(fcap_pkg::OFF_SR, 8'h00);
		wr(fcap_pkg::OFF_CR2, 8'h04);
		wr(fcap_pkg::OFF_CR1, 8'h20);
		wr(fcap_pkg::OFF_CTL, 8'h00);
		repeat (30) @(posedge ref_clk);
		chk({31'h0000_0000, timer_irq}, 32'h0000_0001);
		wr(fcap_pkg::OFF_CTL, 8'h01);
		repeat (2) @(posedge ref_clk);
		chk({31'h0000_0000, timer_irq}, 32'h0000_0000);
		rdchk(fcap_pkg::OFF_SR, 8'h20);
		// Idle external clock freezes the count
		wr(fcap_pkg::OFF_CR2, 8'h0C);
		wr(fcap_pkg::OFF_ALT_COUNT_LOW_BYTE, 8'h00);
		rdchk(fcap_pkg::OFF_ALT_COUNT_LOW_BYTE, 8'hFC);
		rdchk(fcap_pkg::OFF_SR, 8'h20);
		wb(1'b0, fcap_pkg::OFF_CLR, 8'h00, v1);
		rdchk(fcap_pkg::OFF_SR, 8'h00);
		// External clock, rising then falling edges
		wr(fcap_pkg::OFF_CR1, 8'h00);
		wr(fcap_pkg::OFF_CR2, 8'h0D);
		wr(fcap_pkg::OFF_CLR, 8'h00);
		u_fcap_pin_src.burst(6);
		rdchk(fcap_pkg::OFF_CHR, 8'h00);
		rdchk(fcap_pkg::OFF_CLR, 8'h02);
		wr(fcap_pkg::OFF_CR2, 8'h0C);
		wr(fcap_pkg::OFF_CLR, 8'h00);
		u_fcap_pin_src.burst(3);
		rdchk(fcap_pkg::OFF_CHR, 8'hFF);
		rdchk(fcap_pkg::OFF_CLR, 8'hFF);
		// Divide by eight: 66 clocks give eight or nine counts
		wr(fcap_pkg::OFF_CR2, 8'h08);
		wr(fcap_pkg::OFF_CLR, 8'h00);
		repeat (64) @(posedge ref_clk);
		wb(1'b0, fcap_pkg::OFF_CLR, 8'h00, v1);
		chk({31'h0000_0000, (v1 == 8'h04) || (v1 == 8'h05)}, 32'h0000_0001);
		// Captures: ch1 rising, ch2 falling
		wr(fcap_pkg::OFF_CR2, 8'h0D);
		wr(fcap_pkg::OFF_CR1, 8'h82);
		rdchk(fcap_pkg::OFF_SR, 8'h20);
		wr(fcap_pkg::OFF_CLR, 8'h00);
		wr(fcap_pkg::OFF_CTL, 8'h00);
		u_fcap_pin_src.set_cap(0, 1'b1);
		chk({31'h0000_0000, timer_irq}, 32'h0000_0001);
		rdchk(fcap_pkg::OFF_SR, 8'h80);
		u_fcap_pin_src.burst(2);
		rdchk(fcap_pkg::OFF_IC1H, 8'hFF);
		u_fcap_pin_src.set_cap(0, 1'b0);
		u_fcap_pin_src.set_cap(0, 1'b1);
		rdchk(fcap_pkg::OFF_IC1L, 8'hFC);
		rdchk(fcap_pkg::OFF_SR, 8'h00);
		chk({31'h0000_0000, timer_irq}, 32'h0000_0000);
		u_fcap_pin_src.set_cap(0, 1'b0);
		u_fcap_pin_src.set_cap(0, 1'b1);
		u_fcap_pin_src.set_cap(1, 1'b1);
		rdchk(fcap_pkg::OFF_SR, 8'h80);
		u_fcap_pin_src.set_cap(1, 1'b0);
		rdchk(fcap_pkg::OFF_SR, 8'h90);
		rdchk(fcap_pkg::OFF_IC1H, 8'hFF);
		rdchk(fcap_pkg::OFF_IC1L, 8'hFE);
		rdchk(fcap_pkg::OFF_IC2H, 8'hFF);
		rdchk(fcap_pkg::OFF_IC2L, 8'hFE);
		// Single pulse mode leaves channel one idle
		wr(fcap_pkg::OFF_CR2, 8'h1D);
		u_fcap_pin_src.set_cap(0, 1'b0);
		u_fcap_pin_src.set_cap(0, 1'b1);
		rdchk(fcap_pkg::OFF_SR, 8'h00);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
